// File: mie_exec.sv
// execute stage for a subset of an 8-bit microcontroller instruction set
// assumes an AHB-Lite master issues ops by writing the control word; data memory is local
`include "mie_params.svh"
module mie_exec #(
   parameter int DATA_W = `MIE_DATA_W,
   parameter int PC_W = `MIE_PC_W,
   parameter int WDT_W = `MIE_WDT_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic watchdog_tick,
   output logic [WDT_W-1:0] watchdog_counter,
   output logic busy
);
   // bus capture
   logic addr_ok_q;
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   wire logic take = hsel && hready && htrans[1];
   // only the first page is mapped; anything above reads zero and ignores writes
   wire logic rd_in_map = (haddr[31:8] == `MIE_PAGE_ZERO);
   // core state
   logic [DATA_W-1:0] work_q;
   logic [DATA_W-1:0] mem_q [0:(1<<`MIE_MEM_AW)-1];
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] stack_q [0:`MIE_STACK_D-1];
   logic [`MIE_SP_W-1:0] sp_q;
   logic carry_q;
   logic half_carry_flag_q;
   logic signed_wrap_flag_q;
   logic zero_q;
   logic watchdog_expiry_flag_q;
   logic powerdown_flag_q;
   logic [WDT_W-1:0] wdt_q;
   mie_pkg::mie_state_t st_q;
   mie_pkg::mie_pre_t pre_q;
   logic [DATA_W-1:0] res_q;
   logic [PC_W-1:0] target_q;

   // control word: [4:0] op, [15:8] address, [23:16] immediate, [26:24] bit,
   // [31:27] unused; call target is in [28:16] instead
   // a control write that lands while a call is busy is dropped
   wire logic issue = wr_q && addr_ok_q && (addr_q == `MIE_REG_CTRL) && (st_q == mie_pkg::MIE_ST_IDLE);
   wire mie_pkg::mie_op_t op = issue ? mie_pkg::mie_op_t'(hwdata[`MIE_OP_W-1:0]) : mie_pkg::MIE_OP_NOP;
   wire logic [`MIE_MEM_AW-1:0] maddr = hwdata[15:8];
   wire logic [DATA_W-1:0] imm = hwdata[23:16];
   wire logic [2:0] bsel = hwdata[26:24];
   wire logic [PC_W-1:0] target = hwdata[16+PC_W-1:16];
   // unwritten memory bytes read as unknown until stored
   wire logic [DATA_W-1:0] mval = mem_q[maddr];

   // operand select and adder
   wire logic use_imm = (op == mie_pkg::MIE_OP_SUM_IMM_TO_WORK);
   wire logic use_cin = (op == mie_pkg::MIE_OP_SUM_CARRY_TO_WORK) ||
                        (op == mie_pkg::MIE_OP_SUM_CARRY_TO_MEM);
   wire logic [DATA_W-1:0] opb = use_imm ? imm : mval;
   wire logic cin = use_cin & carry_q;
   wire logic [DATA_W:0] sum = {1'b0, work_q} + {1'b0, opb} + {{DATA_W{1'b0}}, cin};
   wire logic [4:0] low = {1'b0, work_q[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   wire logic [DATA_W-1:0] res_sum = sum[DATA_W-1:0];
   wire logic c_new = sum[DATA_W];
   wire logic h_new = low[`MIE_HALF_BIT];
   wire logic v_new = (work_q[`MIE_MSB] == opb[`MIE_MSB]) && (res_sum[`MIE_MSB] != work_q[`MIE_MSB]);
   wire logic [DATA_W-1:0] res_and = work_q & opb;
   wire logic [DATA_W-1:0] res_inv = ~mval;
   wire logic [DATA_W-1:0] res_bclr = mval & ~(8'h01 << bsel);

   wire logic is_add_w = (op == mie_pkg::MIE_OP_SUM_CARRY_TO_WORK) ||
                         (op == mie_pkg::MIE_OP_SUM_MEM_TO_WORK) || use_imm;
   wire logic is_add_m = (op == mie_pkg::MIE_OP_SUM_CARRY_TO_MEM) ||
                         (op == mie_pkg::MIE_OP_SUM_TO_MEM);
   wire logic is_and_w = (op == mie_pkg::MIE_OP_CONJ_MEM_TO_WORK) ||
                         (op == mie_pkg::MIE_OP_CONJ_IMM_TO_WORK);
   wire logic and_imm = (op == mie_pkg::MIE_OP_CONJ_IMM_TO_WORK);
   wire logic [DATA_W-1:0] res_and_w = work_q & (and_imm ? imm : mval);

   logic mem_we;
   logic [DATA_W-1:0] mem_wd;
   always_comb begin
      mem_we = 1'b1;
      mem_wd = res_sum;
      case (op)
         mie_pkg::MIE_OP_SUM_CARRY_TO_MEM,
         mie_pkg::MIE_OP_SUM_TO_MEM: mem_wd = res_sum;
         mie_pkg::MIE_OP_CONJ_TO_MEM: mem_wd = res_and;
         mie_pkg::MIE_OP_ZERO_FILL: mem_wd = `MIE_BYTE_ZERO;
         mie_pkg::MIE_OP_BIT_CLEAR: mem_wd = res_bclr;
         mie_pkg::MIE_OP_INVERT_MEM: mem_wd = res_inv;
         default: mem_we = 1'b0;
      endcase
   end

   // watchdog pair: takes effect when the other half was the previous pre-clear
   wire logic pre1 = (op == mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_FIRST);
   wire logic pre2 = (op == mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_SECOND);
   wire logic pair_done = (pre1 && pre_q == mie_pkg::MIE_PRE_SECOND) ||
                          (pre2 && pre_q == mie_pkg::MIE_PRE_FIRST);
   wire logic wd_clear = (op == mie_pkg::MIE_OP_WATCHDOG_RESTART) || pair_done;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ok_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         addr_ok_q <= take && rd_in_map;
         wr_q <= take && hwrite;
         addr_q <= haddr[7:0];
         rdata_q <= rdata_d;
      end
   end

   // read data is captured at the address phase and shown in the data phase
   wire logic [PC_W-1:0] stack_top = stack_q[sp_q - 3'h1];
   wire logic [31:0] stat_word = {22'h0, busy, powerdown_flag_q, watchdog_expiry_flag_q,
      signed_wrap_flag_q, half_carry_flag_q, zero_q, carry_q, sp_q};
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_in_map) begin
         case (haddr[7:0])
            `MIE_REG_STAT: rdata_d = stat_word;
            `MIE_REG_RES: rdata_d = {16'h0, res_q, work_q};
            `MIE_REG_PC: rdata_d = {{(32-PC_W){1'b0}}, pc_q};
            `MIE_REG_TOP: rdata_d = {{(32-PC_W){1'b0}}, stack_top};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = rdata_q;
   // zero wait states: every transfer completes at once
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // next flags, work register and last result
   logic [DATA_W-1:0] work_d;
   logic [DATA_W-1:0] res_d;
   logic carry_d;
   logic half_carry_flag_d;
   logic signed_wrap_flag_d;
   logic zero_d;
   always_comb begin
      work_d = work_q;
      res_d = res_q;
      carry_d = carry_q;
      half_carry_flag_d = half_carry_flag_q;
      signed_wrap_flag_d = signed_wrap_flag_q;
      zero_d = zero_q;
      if (is_add_w || is_add_m) begin
         carry_d = c_new;
         half_carry_flag_d = h_new;
         signed_wrap_flag_d = v_new;
         zero_d = (res_sum == `MIE_BYTE_ZERO);
         res_d = res_sum;
      end
      if (is_add_w) begin
         work_d = res_sum;
      end
      if (is_and_w) begin
         work_d = res_and_w;
         zero_d = (res_and_w == `MIE_BYTE_ZERO);
         res_d = res_and_w;
      end
      if (op == mie_pkg::MIE_OP_INVERT_MEM) begin
         zero_d = (res_inv == `MIE_BYTE_ZERO);
      end
      // memory writes also show their byte in the result register
      if (mem_we) begin
         res_d = mem_wd;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         work_q <= 8'h00;
         res_q <= 8'h00;
         carry_q <= 1'b0;
         half_carry_flag_q <= 1'b0;
         signed_wrap_flag_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         work_q <= work_d;
         res_q <= res_d;
         carry_q <= carry_d;
         half_carry_flag_q <= half_carry_flag_d;
         signed_wrap_flag_q <= signed_wrap_flag_d;
         zero_q <= zero_d;
      end
   end

   // data memory has no reset
   always_ff @(posedge hclk) begin
      if (mem_we) begin
         mem_q[maddr] <= mem_wd;
      end
   end

   // push and jump
   // the stack pointer wraps silently after eight nested calls
   always_ff @(posedge hclk) begin
      if (op == mie_pkg::MIE_OP_CALL) begin
         stack_q[sp_q] <= pc_q + `MIE_PC_STEP;
      end
   end

   // second call cycle loads target; others advance pc at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= mie_pkg::MIE_ST_IDLE;
         pc_q <= '0;
         sp_q <= '0;
         target_q <= '0;
      end else begin
         case (st_q)
            mie_pkg::MIE_ST_IDLE: begin
               if (op == mie_pkg::MIE_OP_CALL) begin
                  st_q <= mie_pkg::MIE_ST_CALL2;
                  sp_q <= sp_q + 3'h1;
                  target_q <= target;
               end else if (issue) begin
                  pc_q <= pc_q + `MIE_PC_STEP;
               end
            end
            mie_pkg::MIE_ST_CALL2: begin
               pc_q <= target_q;
               st_q <= mie_pkg::MIE_ST_IDLE;
            end
            default: st_q <= mie_pkg::MIE_ST_IDLE;
         endcase
      end
   end
   assign busy = (st_q == mie_pkg::MIE_ST_CALL2);

   // flags hold unless cleared or set
   wire logic wdt_wrap = watchdog_tick && (&wdt_q);
   mie_pkg::mie_pre_t pre_d;
   logic [WDT_W-1:0] wdt_d;
   logic watchdog_expiry_flag_d;
   logic powerdown_flag_d;
   always_comb begin
      pre_d = pre_q;
      wdt_d = wdt_q;
      watchdog_expiry_flag_d = watchdog_expiry_flag_q;
      powerdown_flag_d = powerdown_flag_q;
      if (pair_done) begin
         pre_d = mie_pkg::MIE_PRE_NONE;
      end else if (pre1) begin
         pre_d = mie_pkg::MIE_PRE_FIRST;
      end else if (pre2) begin
         pre_d = mie_pkg::MIE_PRE_SECOND;
      end
      if (wd_clear) begin
         wdt_d = '0;
         powerdown_flag_d = 1'b0;
         // a wrap in the clearing cycle still sets the expiry flag
         watchdog_expiry_flag_d = wdt_wrap;
      end else if (watchdog_tick) begin
         wdt_d = wdt_q + 1'b1;
         if (wdt_wrap) begin
            watchdog_expiry_flag_d = 1'b1;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= mie_pkg::MIE_PRE_NONE;
         wdt_q <= '0;
         watchdog_expiry_flag_q <= 1'b0;
         powerdown_flag_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         wdt_q <= wdt_d;
         watchdog_expiry_flag_q <= watchdog_expiry_flag_d;
         powerdown_flag_q <= powerdown_flag_d;
      end
   end
   assign watchdog_counter = wdt_q;
endmodule

// File: mie_exec_sva.sv
// port checks for the execute subset: bus answer, call timing, watchdog count
// assumes the enum order of mie_pkg for the op field of the control word
module mie_exec_sva #(
   parameter int WDT_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic watchdog_tick,
   input wire logic [WDT_W-1:0] watchdog_counter,
   input wire logic busy
);
   logic wr_q;
   wire rd_ph = hsel && hready && htrans[1] && !hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_q <= 1'b0;
      else wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // control word in its data phase, accepted
   sequence op_s(mie_pkg::mie_op_t o);
      wr_q && hwdata[4:0] == o && !busy;
   endsequence
   ready_high_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   call_busy_a: assert property (op_s(mie_pkg::MIE_OP_CALL) |=> busy ##1 !busy)
      else $error("call not two cycles");
   busy_cause_a: assert property ($rose(busy) |-> $past(wr_q && hwdata[4:0] == 5'h09))
      else $error("busy without call");
   wdt_restart_a: assert property (op_s(mie_pkg::MIE_OP_WATCHDOG_RESTART)
      |=> watchdog_counter == '0) else $error("restart left count");
   tick_count_a: assert property (watchdog_tick && !wr_q
      |=> watchdog_counter == $past(watchdog_counter) + 1'b1) else $error("tick not counted");
   hold_count_a: assert property (!watchdog_tick && !wr_q |=> $stable(watchdog_counter))
      else $error("count moved");
   unmapped_zero_a: assert property (rd_ph && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   stat_busy_a: assert property (rd_ph && haddr == 32'h4 |=> hrdata[9] == $past(busy))
      else $error("status busy bit wrong");
endmodule
bind mie_exec mie_exec_sva #(.WDT_W(WDT_W)) u_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .watchdog_tick(watchdog_tick), .watchdog_counter(watchdog_counter), .busy(busy));

// File: mie_params.svh
// timing and field constants for the instruction execute subset
// assumes a single 100 MHz clock and an external sequencer feeding one op at a time
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH
`define MIE_DATA_W 8
`define MIE_PC_W 13
`define MIE_WDT_W 16
`define MIE_STACK_D 8
`define MIE_SP_W 3
`define MIE_BYTE_ZERO 8'h00
`define MIE_PC_STEP 13'h0001
`define MIE_HALF_BIT 4
`define MIE_MSB 7
`define MIE_MEM_AW 8
`define MIE_OP_W 5
`define MIE_REG_CTRL 8'h00
`define MIE_REG_STAT 8'h04
`define MIE_REG_RES 8'h08
`define MIE_REG_PC 8'h0C
`define MIE_REG_TOP 8'h10
`define MIE_PAGE_ZERO 24'h00_0000
`endif

// File: mie_pkg.sv
// types of the instruction execute subset
package mie_pkg;
   typedef enum logic [4:0] {
      MIE_OP_NOP,
      MIE_OP_SUM_CARRY_TO_WORK,
      MIE_OP_SUM_CARRY_TO_MEM,
      MIE_OP_SUM_MEM_TO_WORK,
      MIE_OP_SUM_IMM_TO_WORK,
      MIE_OP_SUM_TO_MEM,
      MIE_OP_CONJ_MEM_TO_WORK,
      MIE_OP_CONJ_IMM_TO_WORK,
      MIE_OP_CONJ_TO_MEM,
      MIE_OP_CALL,
      MIE_OP_ZERO_FILL,
      MIE_OP_BIT_CLEAR,
      MIE_OP_WATCHDOG_RESTART,
      MIE_OP_WATCHDOG_PRECLEAR_FIRST,
      MIE_OP_WATCHDOG_PRECLEAR_SECOND,
      MIE_OP_INVERT_MEM
   } mie_op_t;
   typedef enum {MIE_ST_IDLE, MIE_ST_CALL2} mie_state_t;
   typedef enum {MIE_PRE_NONE, MIE_PRE_FIRST, MIE_PRE_SECOND} mie_pre_t;
endpackage

// File: test_mcu_instruction_execute_subset.sv
// self-checking bench for the execute subset, driving its bus port directly
// assumes zero-wait answers are still waited for; hready loops back from hreadyout
module test_mcu_instruction_execute_subset;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WDT_W = 4;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, watchdog_tick = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [3:0] fm = 4'h2;
   logic hreadyout, hresp, busy;
   logic [WDT_W-1:0] watchdog_counter;
   wire hready = hreadyout;
   int n_errors = 0, checked = 0;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
   mie_exec #(.WDT_W(WDT_W)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .watchdog_tick(watchdog_tick), .watchdog_counter(watchdog_counter), .busy(busy));
   initial forever #5 hclk = ~hclk;
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic op(mie_pkg::mie_op_t o, logic [7:0] m, logic [7:0] i, logic [2:0] b);
      bus(1'b1, 32'h0, {5'h0, b, i, m, 3'h0, o});
   endtask
   // e is {last result byte, work register}, f is {wrap, half, zero, carry}
   task automatic step(mie_pkg::mie_op_t o, logic [7:0] i, logic [2:0] b, logic [15:0] e,
                       logic [3:0] f);
      op(o, 8'h10, i, b);
      bus(1'b0, 32'h8, 32'h0);
      `CHK(rd[15:0], e)
      bus(1'b0, 32'h4, 32'h0);
      `CHK(rd[6:3] & fm, f)
      fm = 4'hF;
   endtask
   task t_map;
      bus(1'b1, 32'h4, 32'hFFFFFFFF);
      bus(1'b0, 32'h100, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   task t_alu;
      step(mie_pkg::MIE_OP_CONJ_IMM_TO_WORK, 8'h00, 3'h0, 16'h0000, 4'h2);
      step(mie_pkg::MIE_OP_SUM_IMM_TO_WORK, 8'h8F, 3'h0, 16'h8F8F, 4'h0);
      step(mie_pkg::MIE_OP_SUM_IMM_TO_WORK, 8'h71, 3'h0, 16'h0000, 4'h7);
      step(mie_pkg::MIE_OP_ZERO_FILL, 8'h00, 3'h0, 16'h0000, 4'h7);
      step(mie_pkg::MIE_OP_SUM_IMM_TO_WORK, 8'h7F, 3'h0, 16'h7F7F, 4'h0);
      step(mie_pkg::MIE_OP_SUM_TO_MEM, 8'h00, 3'h0, 16'h7F7F, 4'h0);
      step(mie_pkg::MIE_OP_SUM_CARRY_TO_MEM, 8'h00, 3'h0, 16'hFE7F, 4'hC);
      step(mie_pkg::MIE_OP_SUM_MEM_TO_WORK, 8'h00, 3'h0, 16'h7D7D, 4'h5);
      step(mie_pkg::MIE_OP_SUM_CARRY_TO_WORK, 8'h00, 3'h0, 16'h7C7C, 4'h5);
      step(mie_pkg::MIE_OP_CONJ_MEM_TO_WORK, 8'h00, 3'h0, 16'h7C7C, 4'h5);
      step(mie_pkg::MIE_OP_CONJ_TO_MEM, 8'h00, 3'h0, 16'h7C7C, 4'h5);
      step(mie_pkg::MIE_OP_BIT_CLEAR, 8'h00, 3'h2, 16'h787C, 4'h5);
      step(mie_pkg::MIE_OP_INVERT_MEM, 8'h00, 3'h0, 16'h877C, 4'h5);
      step(mie_pkg::MIE_OP_CONJ_IMM_TO_WORK, 8'h80, 3'h0, 16'h0000, 4'h7);
   endtask
   task t_call;
      op(mie_pkg::MIE_OP_CALL, 8'h10, 8'hA5, 3'h5);
      @(negedge hclk);
      `CHK(busy, 1'b1)
      @(negedge hclk);
      `CHK(busy, 1'b0)
      bus(1'b0, 32'h8, 32'h0);
      `CHK(rd[15:0], 16'h0000)
      bus(1'b0, 32'h4, 32'h0);
      `CHK(rd[9:0], 10'h039)
      bus(1'b0, 32'h10, 32'h0);
      `CHK(rd[12:0], 13'h000F)
      bus(1'b0, 32'hC, 32'h0);
      `CHK(rd[12:0], 13'h05A5)
      op(mie_pkg::MIE_OP_NOP, 8'h00, 8'h00, 3'h0);
      bus(1'b0, 32'hC, 32'h0);
      `CHK(rd[12:0], 13'h05A6)
      bus(1'b0, 32'h10C, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   task automatic wdt(mie_pkg::mie_op_t o, int n, logic [3:0] c, logic [1:0] f);
      @(posedge hclk);
      watchdog_tick <= n > 0;
      repeat (n) @(posedge hclk);
      watchdog_tick <= 1'b0;
      op(o, 8'h00, 8'h00, 3'h0);
      bus(1'b0, 32'h4, 32'h0);
      `CHK(watchdog_counter, c)
      `CHK(rd[8:7], f)
   endtask
   task t_wdt;
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_FIRST, 19, 4'h3, 2'b01);
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_FIRST, 0, 4'h3, 2'b01);
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_SECOND, 0, 4'h0, 2'b00);
      wdt(mie_pkg::MIE_OP_NOP, 19, 4'h3, 2'b01);
      wdt(mie_pkg::MIE_OP_WATCHDOG_RESTART, 0, 4'h0, 2'b00);
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_SECOND, 19, 4'h3, 2'b01);
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_SECOND, 0, 4'h3, 2'b01);
      wdt(mie_pkg::MIE_OP_WATCHDOG_PRECLEAR_FIRST, 0, 4'h0, 2'b00);
   endtask
   task report_and_stop;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_map;
      t_alu;
      t_call;
      t_wdt;
      report_and_stop;
   end
endmodule
